// >>> hw/cfgld_dev.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - bus transfers up to 1MHz work
// - host reads/writes registers and programs nonvolatile memory
// - slave address from store, low bit optionally from strap pin
// - full lock, or limited with 16-bit password
// - limited access blocks writes and/or reads
// - telemetry-only: telemetry reads only
// - pin protection engages after address sampled
// - pin high lifts protection when enabled
// - packet error check on transactions
// - protocol generation from store or mode pin
// - memory mode: loop2 target half loop1
// - interface generation from store or telemetry pin
// - pulse outputs high impedance until soft-start
// - phase detect after reset marks unpopulated
// - detect, then load config, then trim
// - host may overwrite loaded working registers
// - enable and thermal low: test address
// - test mode defers load until pin high
// - outputs run only with rails and enable
// - tri-level or three-state output signalling
// - config crc failure blocks regulation
// - load within 1ms, trim within 4ms
module cfgld_dev
  import cfgld_pkg::*;
#(
  parameter logic [19:0] TRIM_LEN = 20'(TRIM_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  cfgld_if.dev bus,
  output logic [3:0] nvm_addr,
  input wire logic [15:0] nvm_rdata,
  output logic nvm_wr,
  output logic [15:0] nvm_wdata,
  input wire logic input_voltage_sense,
  input wire logic supply_ok,
  input wire logic [NPH-1:0] phase_sense,
  input wire logic [15:0] telemetry_word,
  output logic [NPH-1:0] pwm_oe_n,
  output logic regulation_run,
  output logic trilevel_driver_signalling,
  output logic protocol_newer,
  output logic iface_gen_newer,
  output logic [15:0] loop2_target,
  output logic config_crc_error,
  output logic [NPH-1:0] phase_populated
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    cfgld_state_t st;
    logic [S_PH+NPH-1:0] s1;
    logic [S_PH+NPH-1:0] s2;
    logic [NSTORE-1:0][15:0] regs;
    logic [3:0] ld;
    logic [7:0] crc;
    logic [19:0] tcnt;
    logic [NPH-1:0] pop;
    logic crc_err;
    logic unlocked;
    logic prot_eng;
    logic addr_lvl;
    logic interface_mode_select_pin_lvl;
    logic svt_lvl;
    logic ack;
    logic nak;
    logic [15:0] rdata;
    logic [7:0] rpec;
    logic [3:0] nvm_addr;
    logic nvm_wr;
    logic [15:0] nvm_wdata;
    logic [NPH-1:0] oe_n;
    logic run;
    logic tri_lvl;
    logic newer_proto;
    logic newer_iface;
    logic [15:0] loop2;
  } cfgld_dev_state_t;

  cfgld_dev_state_t q;
  cfgld_dev_state_t next_q;

  logic [15:0] cfg;
  logic test_mode;
  logic [6:0] my_addr;
  logic bus_open;
  logic hit;
  logic pec_ok;
  logic tele;
  logic prot_active;
  logic wr_ok;
  logic rd_ok;
  logic [15:0] status;
  logic [15:0] rd_val;
  logic [15:0] loop2_val;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign cfg = q.regs[IDX_CFG];
  assign test_mode = !q.s2[S_EN] && !q.s2[S_HOT];
  // stored address, low bit optionally from the strap
  assign my_addr = test_mode ? TEST_ADDR :
                   cfg[B_ADDRPIN] ? {q.regs[IDX_ADDR][6:1], q.addr_lvl} :
                   q.regs[IDX_ADDR][6:0];
  assign bus_open = (q.st == ST_HOLD) || (q.st == ST_TRIM) ||
                    (q.st == ST_READY) || (q.st == ST_FAIL);
  assign hit = bus.req && bus_open && (bus.dev_addr == my_addr);
  assign pec_ok = bus.pec == cfgld_pec(bus.dev_addr, bus.wr, bus.reg_idx,
                                      bus.wr ? bus.wdata : 16'h0000);
  assign tele = bus.reg_idx >= TELE_FIRST;
  // protection holds while the shared pin is low
  assign prot_active = cfg[B_PINPROT] && q.prot_eng && !q.s2[S_ADDR];
  assign wr_ok = (cfg[1:0] != LOCK_FULL) && (cfg[1:0] != LOCK_TELE) &&
                 !tele && !prot_active &&
                 !(cfg[1:0] == LOCK_LIMITED && !q.unlocked &&
                   cfg[B_WRBLK] && bus.reg_idx != IDX_UNLOCK);
  assign rd_ok = (cfg[1:0] != LOCK_FULL) &&
                 ((cfg[1:0] != LOCK_TELE) || tele) &&
                 !(cfg[1:0] == LOCK_LIMITED && !q.unlocked &&
                   cfg[B_RDBLK]);
  assign loop2_val = cfg[B_MEMMODE] ? {1'b0, q.regs[IDX_LOOP1][15:1]} :
                     q.regs[IDX_LOOP2];
  assign status = {6'h00, q.st, q.pop, q.crc_err, q.unlocked, prot_active,
                   test_mode};

  always_comb
  begin
    rd_val = 16'h0000;
    if (bus.reg_idx == IDX_LOOP2)
    begin
      rd_val = loop2_val;
    end
    else if (bus.reg_idx < 4'(NSTORE))
    begin
      rd_val = q.regs[bus.reg_idx];
    end
    else if (bus.reg_idx == IDX_STATUS)
    begin
      rd_val = status;
    end
    else if (bus.reg_idx == IDX_TELEM)
    begin
      rd_val = telemetry_word;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_q = q;
    next_q.s1 = {phase_sense, input_voltage_sense, bus.serial_telemetry_pin,
                 bus.interface_mode_select_pin, bus.addr_pin,
                 bus.thermal_alert_pin, bus.enable_pin};
    next_q.s2 = q.s1;
    next_q.ack = 1'b0;
    next_q.nak = 1'b0;
    next_q.nvm_wr = 1'b0;
    case (q.st)
      ST_POR:
      begin
        next_q.ld = q.ld + 4'h1;
        if (q.ld == 4'(POR_SETTLE))
        begin
          next_q.st = ST_DETECT;
        end
      end
      ST_DETECT:
      begin
        // nvm_addr still at word 0 here, so the enable bit is live
        if (!nvm_rdata[B_PHDET])
        begin
          next_q.pop = '1;
          next_q.st = ST_HOLD;
        end
        else if (q.s2[S_VIN])
        begin
          next_q.pop = q.s2[S_PH +: NPH];
          next_q.st = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (!test_mode)
        begin
          next_q.st = ST_LOAD;
          next_q.ld = 4'h0;
          next_q.nvm_addr = 4'h0;
          next_q.crc = 8'h00;
        end
      end
      ST_LOAD:
      begin
        // one word a cycle: 16 cycles, far inside the load limit
        if (q.ld < 4'(NSTORE))
        begin
          next_q.regs[q.ld] = nvm_rdata;
        end
        if (q.ld != IDX_CRC)
        begin
          next_q.crc = cfgld_crc8(cfgld_crc8(q.crc, nvm_rdata[15:8]),
                                  nvm_rdata[7:0]);
          next_q.ld = q.ld + 4'h1;
          next_q.nvm_addr = q.ld + 4'h1;
        end
        else
        begin
          next_q.crc_err = q.crc != nvm_rdata[7:0];
          next_q.addr_lvl = q.s2[S_ADDR];
          next_q.interface_mode_select_pin_lvl = q.s2[S_INTERFACE_MODE_SELECT_PIN];
          next_q.svt_lvl = q.s2[S_SVT];
          next_q.prot_eng = 1'b1;
          next_q.tcnt = 20'h00000;
          next_q.st = (q.crc != nvm_rdata[7:0]) ? ST_FAIL : ST_TRIM;
        end
      end
      ST_TRIM:
      begin
        next_q.tcnt = q.tcnt + 20'h00001;
        if (q.tcnt == TRIM_LEN - 20'h00001)
        begin
          next_q.st = ST_READY;
        end
      end
      ST_READY, ST_FAIL:
      begin
      end
      default:
      begin
        next_q.st = ST_POR;
      end
    endcase

    // host access; a refused one touches nothing
    if (hit)
    begin
      if (!pec_ok || (bus.wr ? !wr_ok : !rd_ok))
      begin
        next_q.nak = 1'b1;
      end
      else if (bus.wr)
      begin
        next_q.ack = 1'b1;
        if (bus.reg_idx < 4'(NSTORE))
        begin
          next_q.regs[bus.reg_idx] = bus.wdata;
        end
        else if (bus.reg_idx == IDX_UNLOCK)
        begin
          next_q.unlocked = bus.wdata == q.regs[IDX_PASSWORD];
        end
        else if (bus.reg_idx == IDX_NVM_CMD && q.st != ST_LOAD)
        begin
          next_q.nvm_wr = 1'b1;
          next_q.nvm_addr = bus.wdata[3:0];
          next_q.nvm_wdata = (bus.wdata[3:0] < 4'(NSTORE)) ?
                             q.regs[bus.wdata[3:0]] : 16'h0000;
        end
      end
      else
      begin
        next_q.ack = 1'b1;
        next_q.rdata = rd_val;
        next_q.rpec = cfgld_pec(bus.dev_addr, 1'b0, bus.reg_idx, rd_val);
      end
    end

    // crc failure never reaches ready, so it never runs
    next_q.run = (q.st == ST_READY) && q.s2[S_EN] && supply_ok &&
                 q.s2[S_VIN];
    next_q.oe_n = ~(q.pop & {NPH{next_q.run}});
    next_q.tri_lvl = cfg[B_TRILVL];
    next_q.newer_proto = cfg[B_PROTO_SRC] ? cfg[B_PROTO_VAL] :
                         !q.interface_mode_select_pin_lvl;
    next_q.newer_iface = cfg[B_IFACE_SRC] ? cfg[B_IFACE_VAL] :
                         q.svt_lvl;
    next_q.loop2 = loop2_val;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= ST_POR;
      q.regs <= {NSTORE{REG_RESET}};
      q.oe_n <= '1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign bus.ack = q.ack;
  assign bus.nak = q.nak;
  assign bus.rdata = q.rdata;
  assign bus.rpec = q.rpec;
  assign nvm_addr = q.nvm_addr;
  assign nvm_wr = q.nvm_wr;
  assign nvm_wdata = q.nvm_wdata;
  assign pwm_oe_n = q.oe_n;
  assign regulation_run = q.run;
  assign trilevel_driver_signalling = q.tri_lvl;
  assign protocol_newer = q.newer_proto;
  assign iface_gen_newer = q.newer_iface;
  assign loop2_target = q.loop2;
  assign config_crc_error = q.crc_err;
  assign phase_populated = q.pop;

endmodule : cfgld_dev
`default_nettype wire

// >>> hw/cfgld_pkg.sv
package cfgld_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int BUS_MIN_PERIOD_NS = 1000;
  localparam int HOST_GAP_CYCLES = (BUS_MIN_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOST_TIMEOUT_CYCLES = 8;
  localparam int LOAD_TIME_US = 1000;
  localparam int LOAD_CYCLES = LOAD_TIME_US * CLK_MHZ;
  localparam int TRIM_TIME_US = 4000;
  localparam int TRIM_CYCLES = TRIM_TIME_US * CLK_MHZ;
  localparam int POR_SETTLE = 2;

  // ****************************************************************
  // working register map of the device
  // ****************************************************************
  localparam int NSTORE = 12;
  localparam int NVM_WORDS = 16;
  localparam logic [3:0] IDX_CFG = 4'h0;
  localparam logic [3:0] IDX_ADDR = 4'h1;
  localparam logic [3:0] IDX_PASSWORD = 4'h2;
  localparam logic [3:0] IDX_LOOP1 = 4'h3;
  localparam logic [3:0] IDX_LOOP2 = 4'h4;
  localparam logic [3:0] IDX_UNLOCK = 4'hC;
  localparam logic [3:0] IDX_NVM_CMD = 4'hD;
  localparam logic [3:0] IDX_STATUS = 4'hE;
  localparam logic [3:0] IDX_TELEM = 4'hF;
  localparam logic [3:0] IDX_CRC = 4'hF;
  localparam logic [3:0] TELE_FIRST = 4'hE;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // config word fields
  localparam int B_LOCK = 0;
  localparam int B_WRBLK = 2;
  localparam int B_RDBLK = 3;
  localparam int B_PINPROT = 4;
  localparam int B_ADDRPIN = 5;
  localparam int B_PROTO_SRC = 6;
  localparam int B_PROTO_VAL = 7;
  localparam int B_IFACE_SRC = 8;
  localparam int B_IFACE_VAL = 9;
  localparam int B_MEMMODE = 10;
  localparam int B_TRILVL = 11;
  localparam int B_PHDET = 12;
  localparam logic [1:0] LOCK_OPEN = 2'h0;
  localparam logic [1:0] LOCK_LIMITED = 2'h1;
  localparam logic [1:0] LOCK_TELE = 2'h2;
  localparam logic [1:0] LOCK_FULL = 2'h3;

  localparam logic [6:0] TEST_ADDR = 7'h0A;

  // synchronised input positions
  localparam int S_EN = 0;
  localparam int S_HOT = 1;
  localparam int S_ADDR = 2;
  localparam int S_INTERFACE_MODE_SELECT_PIN = 3;
  localparam int S_SVT = 4;
  localparam int S_VIN = 5;
  localparam int S_PH = 6;
  localparam int NPH = 3;

  // host register map
  localparam logic [2:0] H_TARGET = 3'h0;
  localparam logic [2:0] H_REG = 3'h1;
  localparam logic [2:0] H_WDATA = 3'h2;
  localparam logic [2:0] H_CTRL = 3'h3;
  localparam logic [2:0] H_STATUS = 3'h4;
  localparam logic [2:0] H_RDATA = 3'h5;
  localparam logic [2:0] H_PINS = 3'h6;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_DETECT = 3'h1,
    ST_HOLD = 3'h3,
    ST_LOAD = 3'h2,
    ST_TRIM = 3'h6,
    ST_READY = 3'h7,
    ST_FAIL = 3'h5
  } cfgld_state_t;

  function automatic logic [7:0] cfgld_crc8(input logic [7:0] c,
                                            input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : cfgld_crc8

  // packet check over address+direction, index and both data bytes
  function automatic logic [7:0] cfgld_pec(input logic [6:0] a,
                                           input logic w,
                                           input logic [3:0] idx,
                                           input logic [15:0] d);
    logic [7:0] c;
    c = cfgld_crc8(8'h00, {a, w});
    c = cfgld_crc8(c, {4'h0, idx});
    c = cfgld_crc8(c, d[15:8]);
    return cfgld_crc8(c, d[7:0]);
  endfunction : cfgld_pec

endpackage : cfgld_pkg

// >>> hw/cfgld_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cfgld_if;
  // transaction channel
  logic req;
  logic wr;
  logic [6:0] dev_addr;
  logic [3:0] reg_idx;
  logic [15:0] wdata;
  logic [7:0] pec;
  logic ack;
  logic nak;
  logic [15:0] rdata;
  logic [7:0] rpec;
  // pins driven by the outside party
  logic enable_pin;
  logic thermal_alert_pin;
  logic addr_pin;
  logic interface_mode_select_pin;
  logic serial_telemetry_pin;

  modport dev (
    input req, wr, dev_addr, reg_idx, wdata, pec,
    input enable_pin, thermal_alert_pin, addr_pin,
    input interface_mode_select_pin, serial_telemetry_pin,
    output ack, nak, rdata, rpec
  );
  modport host (
    output req, wr, dev_addr, reg_idx, wdata, pec,
    output enable_pin, thermal_alert_pin, addr_pin,
    output interface_mode_select_pin, serial_telemetry_pin,
    input ack, nak, rdata, rpec
  );
endinterface : cfgld_if
`default_nettype wire

// >>> hw/cfgld_host.sv
`timescale 1ns/10ps
`default_nettype none
module cfgld_host
  import cfgld_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  cfgld_if.host bus,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [6:0] target;
    logic [3:0] idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [4:0] pins;
    logic busy;
    logic dir_wr;
    logic got_ack;
    logic got_nak;
    logic pec_err;
    logic [7:0] gap;
    logic [3:0] wait_cnt;
    logic pending;
    logic req;
    logic [15:0] rd_out;
    logic [7:0] pec;
  } cfgld_host_state_t;

  cfgld_host_state_t q;
  cfgld_host_state_t next_q;
  logic [15:0] rd_val;

  always_comb
  begin
    case (addr)
      H_TARGET: rd_val = {9'h000, q.target};
      H_REG: rd_val = {12'h000, q.idx};
      H_WDATA: rd_val = q.wdata;
      H_STATUS: rd_val = {12'h000, q.pec_err, q.got_nak, q.got_ack, q.busy};
      H_RDATA: rd_val = q.rdata;
      H_PINS: rd_val = {11'h000, q.pins};
      default: rd_val = 16'h0000;
    endcase
  end

  always_comb
  begin
    next_q = q;
    next_q.req = 1'b0;
    next_q.rd_out = rd ? rd_val : 16'h0000;
    if (q.gap != 8'h00)
    begin
      next_q.gap = q.gap - 8'h01;
    end
    if (wr && !q.busy)
    begin
      case (addr)
        H_TARGET: next_q.target = wdata[6:0];
        H_REG: next_q.idx = wdata[3:0];
        H_WDATA: next_q.wdata = wdata;
        H_CTRL:
        begin
          if (wdata[0])
          begin
            next_q.busy = 1'b1;
            next_q.pending = 1'b1;
            next_q.dir_wr = wdata[1];
            next_q.got_ack = 1'b0;
            next_q.got_nak = 1'b0;
            next_q.pec_err = 1'b0;
            // frozen with the request fields, which hold while busy
            next_q.pec = cfgld_pec(q.target, wdata[1], q.idx,
                                   wdata[1] ? q.wdata : 16'h0000);
          end
        end
        H_PINS: next_q.pins = wdata[4:0];
        default:
        begin
        end
      endcase
    end
    // spacing keeps the transfer rate at or below the bus limit
    if (q.pending && q.gap == 8'h00)
    begin
      next_q.req = 1'b1;
      next_q.pending = 1'b0;
      next_q.gap = 8'(HOST_GAP_CYCLES);
      next_q.wait_cnt = 4'(HOST_TIMEOUT_CYCLES);
    end
    else if (q.busy && !q.pending)
    begin
      if (bus.ack || bus.nak)
      begin
        next_q.busy = 1'b0;
        next_q.got_ack = bus.ack;
        next_q.got_nak = bus.nak;
        if (bus.ack && !q.dir_wr)
        begin
          next_q.rdata = bus.rdata;
          next_q.pec_err = bus.rpec !=
                           cfgld_pec(q.target, 1'b0, q.idx, bus.rdata);
        end
      end
      else if (q.wait_cnt == 4'h0)
      begin
        next_q.busy = 1'b0;
        next_q.got_nak = 1'b1;
      end
      else
      begin
        next_q.wait_cnt = q.wait_cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign bus.req = q.req;
  assign bus.wr = q.dir_wr;
  assign bus.dev_addr = q.target;
  assign bus.reg_idx = q.idx;
  assign bus.wdata = q.wdata;
  assign bus.pec = q.pec;
  assign bus.enable_pin = q.pins[0];
  assign bus.thermal_alert_pin = q.pins[1];
  assign bus.addr_pin = q.pins[2];
  assign bus.interface_mode_select_pin = q.pins[3];
  assign bus.serial_telemetry_pin = q.pins[4];
  assign rdata = q.rd_out;

endmodule : cfgld_host
`default_nettype wire

// >>> sim/cfgld_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cfgld_chk
  import cfgld_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [6:0] dev_addr,
  input wire logic [3:0] reg_idx,
  input wire logic [15:0] wdata,
  input wire logic [7:0] pec,
  input wire logic ack,
  input wire logic nak,
  input wire logic [15:0] rdata,
  input wire logic [7:0] rpec,
  input wire logic enable_pin
);
  // ****************************************
  // request spacing counter
  // ****************************************
  // saturates so a long idle never wraps into a false short gap
  logic [7:0] gap;
  logic seen;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap <= 8'h00;
      seen <= 1'b0;
    end
    else if (req)
    begin
      gap <= 8'h00;
      seen <= 1'b1;
    end
    else if (gap != 8'hFF)
      gap <= gap + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_req_one_cycle: assert property (req |=> !req)
    else $error("request longer than one cycle");
  a_req_gap_kept: assert property (req && seen |->
    gap >= 8'(HOST_GAP_CYCLES - 1)) else $error("requests too close");
  a_req_pec_ok: assert property (req |->
    pec == cfgld_pec(dev_addr, wr, reg_idx, wr ? wdata : 16'h0000))
    else $error("host packet check wrong");
  a_answer_single: assert property (!(ack && nak))
    else $error("ack and nak together");
  a_answer_cause: assert property ((ack || nak) |-> $past(req))
    else $error("answer without request");
  a_read_pec_ok: assert property (ack && !$past(wr) |->
    rpec == cfgld_pec($past(dev_addr), 1'b0, $past(reg_idx), rdata))
    else $error("read packet check wrong");
  a_rdata_held: assert property (!(ack && !$past(wr)) |->
    $stable(rdata)) else $error("read data moved without read");
  a_test_addr_off: assert property (req && dev_addr == TEST_ADDR &&
    enable_pin && $past(enable_pin, 4) |=> !ack && !nak)
    else $error("test address answered outside test mode");
endmodule : cfgld_chk
`default_nettype wire

// >>> sim/config_load_and_bus_access_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module config_load_and_bus_access_tb_top;
  import cfgld_pkg::*;
  localparam logic [6:0] DADDR = 7'h35;
  localparam logic [15:0] ACK = 16'h0002;
  localparam logic [15:0] NAK = 16'h0004;
  localparam logic [15:0] BASE = 16'h1C30;
  logic clk, rst, h_wr, h_rd, nvm_wr, vin, sok, run, tri_o, pnew, inew, crc_e;
  logic [2:0] h_addr, ph, oe_n, pop;
  logic [3:0] nvm_addr;
  logic [15:0] h_wdata, h_rdata, nvm_wdata, tel, l2, pw, l1, v;
  logic [15:0] nvm [16];
  int n_errors = 0;
  int n_checks = 0;
  cfgld_if bus_if ();
  cfgld_host cfgld_host_i (.clk(clk), .rst(rst), .bus(bus_if.host),
    .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd), .rdata(h_rdata));
  // short trim keeps the run small
  cfgld_dev #(.TRIM_LEN(20'h00014)) cfgld_dev_i (.clk(clk), .rst(rst),
    .bus(bus_if.dev), .nvm_addr(nvm_addr), .nvm_rdata(nvm[nvm_addr]),
    .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .input_voltage_sense(vin),
    .supply_ok(sok), .phase_sense(ph), .telemetry_word(tel),
    .pwm_oe_n(oe_n), .regulation_run(run),
    .trilevel_driver_signalling(tri_o), .protocol_newer(pnew),
    .iface_gen_newer(inew), .loop2_target(l2), .config_crc_error(crc_e),
    .phase_populated(pop));
  cfgld_chk cfgld_chk_i (.clk(clk), .rst(rst), .req(bus_if.req),
    .wr(bus_if.wr), .dev_addr(bus_if.dev_addr), .reg_idx(bus_if.reg_idx),
    .wdata(bus_if.wdata), .pec(bus_if.pec), .ack(bus_if.ack),
    .nak(bus_if.nak), .rdata(bus_if.rdata), .rpec(bus_if.rpec),
    .enable_pin(bus_if.enable_pin));
  // ****************************************
  // helpers
  // ****************************************
  always @(posedge clk)
    if (nvm_wr === 1'b1)
      nvm[nvm_addr] <= nvm_wdata;
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    return c;
  endfunction : crc_step
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic boot(input logic [15:0] c, input logic bad);
    logic [7:0] k;
    k = 8'h00;
    rst <= 1'b1;
    nvm[0] = c;
    nvm[1] = 16'h0034;
    nvm[2] = pw;
    nvm[3] = l1;
    for (int i = 4; i < 15; i++)
      nvm[i] = 16'($urandom());
    for (int i = 0; i < 15; i++)
      k = crc_step(crc_step(k, nvm[i][15:8]), nvm[i][7:0]);
    nvm[15] = {8'h00, k ^ {7'h00, bad}};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : boot
  task automatic hw(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge clk);
    h_wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge clk);
    h_rd <= 1'b0;
    // data stands for the cycle after the strobe; take it at its end
    @(posedge clk);
    d = h_rdata;
  endtask : hr
  // one device transfer through the host, then its outcome is compared
  task automatic op(input logic w, input logic [6:0] da,
                    input logic [3:0] idx, input logic [15:0] d,
                    input logic [15:0] exp);
    logic [15:0] st;
    hw(H_TARGET, {9'h000, da});
    hw(H_REG, {12'h000, idx});
    hw(H_WDATA, d);
    hw(H_CTRL, {14'h0000, w, 1'b1});
    st = 16'h0001;
    for (int i = 0; i < 400 && st[0] !== 1'b0; i++)
      hr(H_STATUS, st);
    chk("status", st & 16'h000F, exp);
    if (!w)
      hr(H_RDATA, v);
  endtask : op
  task automatic power_up;
    hw(H_PINS, 16'h001D);
    repeat (80) @(posedge clk);
  endtask : power_up
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(50620));
    {rst, h_wr, h_rd, h_addr, h_wdata} = {1'b1, 21'h000000};
    {vin, sok, ph} = 5'h1D;
    tel = 16'($urandom());
    pw = 16'($urandom());
    l1 = 16'($urandom());
    boot(BASE, 1'b0);
    repeat (60) @(posedge clk);
    chk("oe_idle", {13'h0000, oe_n}, 16'h0007);
    op(1'b0, TEST_ADDR, IDX_STATUS, 16'h0000, ACK);
    chk("test_bit", {15'h0000, v[0]}, 16'h0001);
    chk("no_load", l2, 16'h0000);
    power_up();
    chk("phases", {13'h0000, pop}, 16'h0005);
    chk("modes", {13'h0000, tri_o, pnew, inew}, 16'h0005);
    chk("run", {12'h000, run, oe_n}, 16'h000A);
    chk("loop2", l2, {1'b0, l1[15:1]});
    op(1'b0, TEST_ADDR, IDX_LOOP1, 16'h0000, NAK);
    op(1'b0, DADDR, IDX_LOOP1, 16'h0000, ACK);
    chk("loop1", v, l1);
    l1 = 16'($urandom());
    op(1'b1, DADDR, IDX_LOOP1, l1, ACK);
    op(1'b0, DADDR, IDX_LOOP1, 16'h0000, ACK);
    chk("loop1_wr", v, l1);
    chk("loop2_wr", l2, {1'b0, l1[15:1]});
    // stored mode sources, trilevel and memory mode off
    op(1'b1, DADDR, IDX_CFG, 16'h11F0, ACK);
    chk("cfgm", {13'h0000, tri_o, pnew, inew}, 16'h0002);
    chk("loop2_own", l2, nvm[4]);
    sok <= 1'b0;
    repeat (5) @(posedge clk);
    chk("stop", {12'h000, run, oe_n}, 16'h0007);
    sok <= 1'b1;
    op(1'b1, DADDR, IDX_NVM_CMD, 16'h0003, ACK);
    repeat (5) @(posedge clk);
    chk("nvm_prog", nvm[3], l1);
    hw(H_PINS, 16'h0019);
    op(1'b1, DADDR, IDX_LOOP1, ~l1, NAK);
    hw(H_PINS, 16'h001D);
    op(1'b1, DADDR, IDX_CFG, BASE | 16'h0005, ACK);
    op(1'b1, DADDR, IDX_LOOP1, ~l1, NAK);
    op(1'b0, DADDR, IDX_LOOP1, 16'h0000, ACK);
    chk("kept", v, l1);
    op(1'b1, DADDR, IDX_UNLOCK, pw ^ 16'h0001, ACK);
    op(1'b1, DADDR, IDX_LOOP1, ~l1, NAK);
    op(1'b1, DADDR, IDX_UNLOCK, pw, ACK);
    op(1'b1, DADDR, IDX_LOOP1, ~l1, ACK);
    op(1'b1, DADDR, IDX_CFG, BASE | 16'h0009, ACK);
    op(1'b1, DADDR, IDX_UNLOCK, ~pw, ACK);
    op(1'b0, DADDR, IDX_LOOP1, 16'h0000, NAK);
    op(1'b1, DADDR, IDX_CFG, BASE | 16'h0002, ACK);
    op(1'b0, DADDR, IDX_TELEM, 16'h0000, ACK);
    chk("telem", v, tel);
    op(1'b0, DADDR, IDX_LOOP1, 16'h0000, NAK);
    op(1'b1, DADDR, IDX_LOOP2, l1, NAK);
    // full lock, phase detection disabled
    boot(16'h0C33, 1'b0);
    power_up();
    op(1'b0, DADDR, IDX_TELEM, 16'h0000, NAK);
    chk("all_phases", {13'h0000, pop}, 16'h0007);
    boot(BASE, 1'b1);
    power_up();
    chk("crc", {15'h0000, crc_e}, 16'h0001);
    chk("crc_run", {12'h000, run, oe_n}, 16'h0007);
    report_and_stop();
  end
endmodule : config_load_and_bus_access_tb_top
`default_nettype wire
